/* gtac_classify.sv */
// Purpose: Decide the fate of one decoded instruction
// Assumes: Inputs stable for the cycle in which the instruction is taken
// Notes: Purely combinational; one cause at most per instruction
`timescale 1ns/1ns
module gtac_classify (
  input wire gtac_pkg::gtac_class_t cls, // Instruction class
  input wire logic guest_mode, // Guest context active
  input wire logic kernel_mode, // Kernel privilege
  input wire logic debug_mode, // Debug mode
  input wire logic [gtac_pkg::CTL_W-1:0] ctl, // Guest control bits
  input wire logic fcd, // Field change disable
  input wire logic sysreg_exists, // Addressed system register exists
  input wire logic sysreg_disabled, // Addressed register disabled
  input wire logic field_change, // Would alter a monitored field
  input wire logic rp_chg, // Would change reduced power bit
  input wire logic iv_chg, // Would change vector select
  output logic trap, // Exception instead of execution
  output logic to_root, // Exception goes to root
  output gtac_pkg::gtac_cause_t cause, // Exception cause
  output logic allow // Instruction may take effect
);
  logic hit;
  always_comb begin
    trap = 1'b0;
    to_root = 1'b1;
    cause = gtac_pkg::gtac_c_none;
    allow = 1'b1;
    hit = 1'b0;
    if (guest_mode && !debug_mode) begin
      case (cls)
        gtac_pkg::gtac_k_resv: begin
          trap = 1'b1;
          to_root = ctl[gtac_pkg::CTL_RI];
          cause = to_root ? gtac_pkg::gtac_c_gri : gtac_pkg::gtac_c_guest;
        end
        gtac_pkg::gtac_k_hcall: begin
          trap = 1'b1;
          to_root = kernel_mode;
          cause = kernel_mode ? gtac_pkg::gtac_c_hcall : gtac_pkg::gtac_c_guest;
        end
        gtac_pkg::gtac_k_rdg, gtac_pkg::gtac_k_wrg, gtac_pkg::gtac_k_tlb: begin
          trap = 1'b1;
          cause = gtac_pkg::gtac_c_gpsi;
        end
        gtac_pkg::gtac_k_plain: hit = 1'b0;
        default: begin
          // Targeted enables for mmu, timer, cache and config, each on its own bit; sysreg hits when missing or disabled
          case (cls)
            gtac_pkg::gtac_k_mmu: hit = ctl[gtac_pkg::CTL_MMU];
            gtac_pkg::gtac_k_timer: hit = ctl[gtac_pkg::CTL_TIMER];
            gtac_pkg::gtac_k_cache: hit = ctl[gtac_pkg::CTL_CACHE];
            gtac_pkg::gtac_k_config: hit = ctl[gtac_pkg::CTL_CONFIG];
            gtac_pkg::gtac_k_sysreg: hit = !sysreg_exists || sysreg_disabled;
            default: hit = 1'b0;
          endcase
          hit = hit || ctl[gtac_pkg::CTL_ALL_PRIV];
          if (!kernel_mode) begin
            trap = 1'b1;
            to_root = 1'b0;
            cause = gtac_pkg::gtac_c_guest;
          end else if (hit) begin
            trap = 1'b1;
            cause = gtac_pkg::gtac_c_gpsi;
          end
        end
      endcase
      if (!trap && !fcd && (field_change || rp_chg || iv_chg)) begin
        trap = 1'b1;
        cause = gtac_pkg::gtac_c_gsfc;
      end
    end else begin
      case (cls)
        gtac_pkg::gtac_k_hcall: begin
          trap = kernel_mode;
          cause = kernel_mode ? gtac_pkg::gtac_c_hcall : gtac_pkg::gtac_c_none;
          allow = kernel_mode;
        end
        gtac_pkg::gtac_k_rdg, gtac_pkg::gtac_k_wrg, gtac_pkg::gtac_k_tlb:
          allow = kernel_mode || debug_mode;
        default: allow = 1'b1;
      endcase
    end
    if (trap) begin
      allow = 1'b0;
    end
  end
endmodule // gtac_classify

/* gtac_pkg.sv */
// Purpose: Shared constants and types of the guest trap and access control block
// Assumes: 32-bit APB words, one core clock
// Notes: Cause codes are local to this block
package gtac_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [7:0] OFS_CTL = 8'h00;
  localparam logic [7:0] OFS_CTL_EXT = 8'h04;
  localparam logic [7:0] OFS_INT_STAT = 8'h08;
  localparam logic [7:0] OFS_INT_MASK = 8'h0c;
  localparam logic [7:0] OFS_EXIT_INFO = 8'h10;
  // guest_control_reg bits
  localparam int unsigned CTL_ALL_PRIV = 0;
  localparam int unsigned CTL_MMU = 1;
  localparam int unsigned CTL_TIMER = 2;
  localparam int unsigned CTL_CACHE = 3;
  localparam int unsigned CTL_CONFIG = 4;
  localparam int unsigned CTL_RI = 5;
  localparam int unsigned CTL_W = 6;
  localparam logic [CTL_W-1:0] CTL_RESET = 6'h00;
  // guest_control_extension_reg bits
  localparam int unsigned EXT_FCD = 0;
  localparam logic EXT_RESET = 1'b0;
  // Interrupt status and mask bits
  localparam int unsigned IRQ_SWFC = 0;
  localparam int unsigned IRQ_HWFC = 1;
  localparam int unsigned IRQ_GPSI = 2;
  localparam int unsigned IRQ_GRI = 3;
  localparam int unsigned IRQ_HCALL = 4;
  localparam int unsigned IRQ_W = 5;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 5'h00;
  // Exit info fields
  localparam int unsigned EXIT_CAUSE_LSB = 0;
  localparam int unsigned EXIT_ROOT_BIT = 3;
  localparam int unsigned EXIT_CNT_LSB = 8;
  localparam int unsigned EXIT_CNT_W = 8;

  typedef enum logic [2:0] {
    gtac_c_none = 3'h0,
    gtac_c_gsfc = 3'h1,
    gtac_c_ghfc = 3'h2,
    gtac_c_gpsi = 3'h3,
    gtac_c_gri = 3'h4,
    gtac_c_hcall = 3'h5,
    gtac_c_guest = 3'h6
  } gtac_cause_t;

  typedef enum logic [3:0] {
    gtac_k_plain = 4'h0,
    gtac_k_priv = 4'h1,
    gtac_k_mmu = 4'h2,
    gtac_k_timer = 4'h3,
    gtac_k_cache = 4'h4,
    gtac_k_config = 4'h5,
    gtac_k_sysreg = 4'h6,
    gtac_k_hcall = 4'h7,
    gtac_k_rdg = 4'h8,
    gtac_k_wrg = 4'h9,
    gtac_k_tlb = 4'ha,
    gtac_k_resv = 4'hb
  } gtac_class_t;

  typedef enum logic [2:0] {
    gtac_t_inv = 3'h0,
    gtac_t_invf = 3'h1,
    gtac_t_probe = 3'h2,
    gtac_t_read = 3'h3,
    gtac_t_wri = 3'h4,
    gtac_t_wrr = 3'h5
  } gtac_tlb_t;

  typedef enum logic [1:0] {
    gtac_st_idle = 2'b00,
    gtac_st_trap = 2'b01,
    gtac_st_done = 2'b11
  } gtac_state_t;

  // Status bit that a root-bound exit sets
  function automatic logic [IRQ_W-1:0] cause_irq(input gtac_cause_t c);
    logic [IRQ_W-1:0] v;
    v = '0;
    case (c)
      gtac_c_gsfc: v[IRQ_SWFC] = 1'b1;
      gtac_c_ghfc: v[IRQ_HWFC] = 1'b1;
      gtac_c_gpsi: v[IRQ_GPSI] = 1'b1;
      gtac_c_gri: v[IRQ_GRI] = 1'b1;
      gtac_c_hcall: v[IRQ_HCALL] = 1'b1;
      default: v = '0;
    endcase
    return v;
  endfunction
endpackage

/* gtac_top.sv */
// Purpose: Guest trap and access control with APB registers
// Assumes: Decoded instruction inputs synchronous to pclk
// Notes: One trap at a time; pipeline acknowledges each trap
// Notes on behaviour
// - Guest write to monitored field traps before it executes; field unchanged.
// - Guest change of reduced power bit goes to hypervisor via field change.
// - Guest change of vector select bit also raises field change exception.
// - Hardware change of a monitored guest field raises hardware field change.
// - Trapped privileged guest kernel instructions raise privileged sensitive exception to root.
// - Catch-all enable traps every privileged guest operation.
// - Four separate enables govern mmu, timer, cache and config access.
// - Missing or disabled system register access traps as privileged sensitive.
// - Redirect bit sends guest reserved instruction exceptions to root.
// - Hypervisor call accepted from guest kernel and root kernel.
// - Root instructions read and write guest system registers.
// - Guest register moves and guest TLB ops also run in Debug mode.
// - Six guest TLB ops from root act on guest TLB.
// - Field change disable suppresses both kinds of field change exception.
// - Mmu access enable set traps guest translation control access.
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ns
module gtac_top #(
  parameter int unsigned CNT_W = gtac_pkg::EXIT_CNT_W // Exit counter width
) (
  input wire logic pclk, // Core clock
  input wire logic presetn, // Async reset, active low
  input wire logic [gtac_pkg::ADDR_W-1:0] paddr, // APB address
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [gtac_pkg::DATA_W-1:0] pwdata, // APB write data
  output logic [gtac_pkg::DATA_W-1:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic instr_valid, // Decoded instruction offered
  input wire gtac_pkg::gtac_class_t instr_class, // Instruction class
  input wire gtac_pkg::gtac_tlb_t tlb_code, // Guest TLB operation
  input wire logic guest_mode, // Guest context active
  input wire logic kernel_mode, // Kernel privilege
  input wire logic debug_mode, // Debug mode
  input wire logic sysreg_exists, // Register exists
  input wire logic sysreg_disabled, // Register disabled
  input wire logic field_change, // Monitored field would change
  input wire logic reduced_power_bit_chg, // Reduced power bit would change
  input wire logic interrupt_vector_sel_chg, // Vector select would change
  input wire logic hw_field_change, // Hardware changed a field
  input wire logic trap_ack, // Pipeline took the trap
  output logic instr_ready, // Instruction may be offered
  output logic instr_commit, // Taken instruction takes effect
  output logic trap_req, // Exception pending
  output logic trap_to_root, // Exception goes to root
  output gtac_pkg::gtac_cause_t trap_cause, // Exception cause
  output logic guest_sysreg_rd, // Guest register read strobe
  output logic guest_sysreg_wr, // Guest register write strobe
  output logic guest_tlb_op, // Guest TLB op strobe
  output gtac_pkg::gtac_tlb_t guest_tlb_code, // Guest TLB op code
  output logic irq // Level interrupt
);
  if (CNT_W < 1 || CNT_W > gtac_pkg::DATA_W - gtac_pkg::EXIT_CNT_LSB) begin : g_chk
    $error("CNT_W must lie in 1..24");
  end

  logic [gtac_pkg::CTL_W-1:0] ctl, next_ctl;
  logic fcd, next_fcd;
  logic [gtac_pkg::IRQ_W-1:0] stat, next_stat, mask, next_mask;
  logic [gtac_pkg::DATA_W-1:0] next_prdata, rdv;
  logic next_pready, next_pslverr, next_irq, acc, wr, hit;
  gtac_pkg::gtac_state_t state, next_state;
  logic hw_pend, next_hw_pend;
  logic next_instr_ready, next_instr_commit, next_trap_req, next_trap_to_root;
  gtac_pkg::gtac_cause_t next_trap_cause, last_cause, next_last_cause;
  logic last_root, next_last_root;
  logic [CNT_W-1:0] exit_cnt, next_exit_cnt;
  logic next_rd, next_wr, next_tlb;
  gtac_pkg::gtac_tlb_t next_tlb_code;
  logic start, start_root, take;
  gtac_pkg::gtac_cause_t start_cause;
  logic c_trap, c_root, c_allow;
  gtac_pkg::gtac_cause_t c_cause;

  gtac_classify u_cls (
    .cls(instr_class),
    .guest_mode(guest_mode),
    .kernel_mode(kernel_mode),
    .debug_mode(debug_mode),
    .ctl(ctl),
    .fcd(fcd),
    .sysreg_exists(sysreg_exists),
    .sysreg_disabled(sysreg_disabled),
    .field_change(field_change),
    .rp_chg(reduced_power_bit_chg),
    .iv_chg(interrupt_vector_sel_chg),
    .trap(c_trap),
    .to_root(c_root),
    .cause(c_cause),
    .allow(c_allow)
  );

  assign take = instr_valid && instr_ready;

  // Trap sequencing
  always_comb begin
    next_state = state;
    next_trap_req = trap_req;
    next_trap_cause = trap_cause;
    next_trap_to_root = trap_to_root;
    next_instr_commit = 1'b0;
    next_rd = 1'b0;
    next_wr = 1'b0;
    next_tlb = 1'b0;
    next_tlb_code = guest_tlb_code;
    next_last_cause = last_cause;
    next_last_root = last_root;
    next_exit_cnt = exit_cnt;
    start = 1'b0;
    start_root = 1'b1;
    start_cause = gtac_pkg::gtac_c_none;
    // A change arriving with the clear is kept
    next_hw_pend = hw_pend && !fcd;
    case (state)
      gtac_pkg::gtac_st_idle: begin
        if (take && c_trap) begin
          start = 1'b1;
          start_cause = c_cause;
          start_root = c_root;
        end else if (take) begin
          next_instr_commit = c_allow;
          next_rd = c_allow && instr_class == gtac_pkg::gtac_k_rdg;
          next_wr = c_allow && instr_class == gtac_pkg::gtac_k_wrg;
          next_tlb = c_allow && instr_class == gtac_pkg::gtac_k_tlb;
          next_tlb_code = tlb_code;
        end else if (hw_pend && !fcd) begin
          start = 1'b1;
          start_cause = gtac_pkg::gtac_c_ghfc;
          next_hw_pend = 1'b0;
        end
      end
      gtac_pkg::gtac_st_trap: begin
        if (trap_ack) begin
          next_trap_req = 1'b0;
          next_state = gtac_pkg::gtac_st_done;
        end
      end
      gtac_pkg::gtac_st_done: next_state = gtac_pkg::gtac_st_idle;
      default: next_state = gtac_pkg::gtac_st_idle;
    endcase
    if (hw_field_change && !fcd) begin
      next_hw_pend = 1'b1;
    end
    if (start) begin
      next_state = gtac_pkg::gtac_st_trap;
      next_trap_req = 1'b1;
      next_trap_cause = start_cause;
      next_trap_to_root = start_root;
      if (start_root) begin
        next_last_cause = start_cause;
        next_last_root = 1'b1;
        next_exit_cnt = exit_cnt + 1'b1;
      end
    end
    // Pending hardware change goes before new instructions
    next_instr_ready = next_state == gtac_pkg::gtac_st_idle && !next_hw_pend;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= gtac_pkg::gtac_st_idle;
      hw_pend <= 1'b0;
      instr_ready <= 1'b0;
      instr_commit <= 1'b0;
      trap_req <= 1'b0;
      trap_cause <= gtac_pkg::gtac_c_none;
      trap_to_root <= 1'b0;
      guest_sysreg_rd <= 1'b0;
      guest_sysreg_wr <= 1'b0;
      guest_tlb_op <= 1'b0;
      guest_tlb_code <= gtac_pkg::gtac_t_inv;
      last_cause <= gtac_pkg::gtac_c_none;
      last_root <= 1'b0;
      exit_cnt <= '0;
    end else begin
      state <= next_state;
      hw_pend <= next_hw_pend;
      instr_ready <= next_instr_ready;
      instr_commit <= next_instr_commit;
      trap_req <= next_trap_req;
      trap_cause <= next_trap_cause;
      trap_to_root <= next_trap_to_root;
      guest_sysreg_rd <= next_rd;
      guest_sysreg_wr <= next_wr;
      guest_tlb_op <= next_tlb;
      guest_tlb_code <= next_tlb_code;
      last_cause <= next_last_cause;
      last_root <= next_last_root;
      exit_cnt <= next_exit_cnt;
    end
  end

  // Registers and APB; one wait state so read data comes from a flop
  always_comb begin
    acc = psel && penable && !pready;
    wr = psel && penable && pready && pwrite;
    hit = 1'b1;
    rdv = '0;
    case (paddr)
      gtac_pkg::OFS_CTL: rdv[gtac_pkg::CTL_W-1:0] = ctl;
      gtac_pkg::OFS_CTL_EXT: rdv[gtac_pkg::EXT_FCD] = fcd;
      gtac_pkg::OFS_INT_STAT: rdv[gtac_pkg::IRQ_W-1:0] = stat;
      gtac_pkg::OFS_INT_MASK: rdv[gtac_pkg::IRQ_W-1:0] = mask;
      gtac_pkg::OFS_EXIT_INFO: begin
        rdv[gtac_pkg::EXIT_CAUSE_LSB +: $bits(gtac_pkg::gtac_cause_t)] = last_cause;
        rdv[gtac_pkg::EXIT_ROOT_BIT] = last_root;
        rdv[gtac_pkg::EXIT_CNT_LSB +: CNT_W] = exit_cnt;
      end
      default: hit = 1'b0;
    endcase
    next_pready = acc;
    next_pslverr = acc && !hit;
    next_prdata = (acc && !pwrite) ? rdv : prdata;
    next_ctl = ctl;
    next_fcd = fcd;
    next_mask = mask;
    next_stat = stat;
    if (wr && paddr == gtac_pkg::OFS_CTL) begin
      next_ctl = pwdata[gtac_pkg::CTL_W-1:0];
    end
    if (wr && paddr == gtac_pkg::OFS_CTL_EXT) begin
      next_fcd = pwdata[gtac_pkg::EXT_FCD];
    end
    if (wr && paddr == gtac_pkg::OFS_INT_MASK) begin
      next_mask = pwdata[gtac_pkg::IRQ_W-1:0];
    end
    if (wr && paddr == gtac_pkg::OFS_INT_STAT) begin
      next_stat = stat & ~pwdata[gtac_pkg::IRQ_W-1:0];
    end
    // Set wins over a clear in the same cycle
    if (start && start_root) begin
      next_stat = next_stat | gtac_pkg::cause_irq(start_cause);
    end
    next_irq = |(next_stat & next_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl <= gtac_pkg::CTL_RESET;
      fcd <= gtac_pkg::EXT_RESET;
      stat <= gtac_pkg::IRQ_RESET;
      mask <= gtac_pkg::IRQ_RESET;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end else begin
      ctl <= next_ctl;
      fcd <= next_fcd;
      stat <= next_stat;
      mask <= next_mask;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      irq <= next_irq;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_sw_field_trap: assert property (take && guest_mode && !debug_mode
    && instr_class == gtac_pkg::gtac_k_plain && field_change && !fcd
    |=> trap_req && trap_cause == gtac_pkg::gtac_c_gsfc && !instr_commit)
    else $error("guest field change not trapped");
  a_rp_field_trap: assert property (take && guest_mode && !debug_mode
    && instr_class == gtac_pkg::gtac_k_plain && reduced_power_bit_chg && !fcd
    |=> trap_req && trap_cause == gtac_pkg::gtac_c_gsfc && !instr_commit)
    else $error("reduced power change not trapped");
  a_iv_field_trap: assert property (take && guest_mode && !debug_mode
    && instr_class == gtac_pkg::gtac_k_plain && interrupt_vector_sel_chg && !fcd
    |=> trap_req && trap_cause == gtac_pkg::gtac_c_gsfc)
    else $error("vector select change not trapped");
  a_hw_field_trap: assert property (state == gtac_pkg::gtac_st_idle && !take
    && !hw_pend && hw_field_change && !fcd ##1 !fcd
    |=> trap_req && trap_cause == gtac_pkg::gtac_c_ghfc && trap_to_root)
    else $error("hardware field change not trapped");
  a_fcd_quiet: assert property ($rose(trap_req) && (trap_cause == gtac_pkg::gtac_c_gsfc
    || trap_cause == gtac_pkg::gtac_c_ghfc) |-> !$past(fcd))
    else $error("field change trap while disabled");
  a_all_priv: assert property (take && guest_mode && !debug_mode && kernel_mode
    && instr_class == gtac_pkg::gtac_k_priv && ctl[gtac_pkg::CTL_ALL_PRIV]
    |=> trap_req && trap_to_root && trap_cause == gtac_pkg::gtac_c_gpsi)
    else $error("catch-all privileged trap missed");
  a_mmu_trap: assert property (take && guest_mode && !debug_mode && kernel_mode
    && instr_class == gtac_pkg::gtac_k_mmu && ctl[gtac_pkg::CTL_MMU]
    |=> trap_req && trap_cause == gtac_pkg::gtac_c_gpsi && !instr_commit)
    else $error("mmu control access not trapped");
  a_ri_redirect: assert property (take && guest_mode && !debug_mode
    && instr_class == gtac_pkg::gtac_k_resv && ctl[gtac_pkg::CTL_RI]
    |=> trap_to_root && trap_cause == gtac_pkg::gtac_c_gri)
    else $error("reserved instruction not redirected");
  a_hcall_kernel: assert property (take && kernel_mode
    && instr_class == gtac_pkg::gtac_k_hcall
    |=> trap_req && trap_to_root && trap_cause == gtac_pkg::gtac_c_hcall)
    else $error("hypervisor call not taken");
  a_gtlb_root: assert property (take && !guest_mode && kernel_mode
    && instr_class == gtac_pkg::gtac_k_tlb |=> guest_tlb_op && !trap_req
    && guest_tlb_code == $past(tlb_code))
    else $error("root guest TLB op lost");
  a_trap_hold: assert property (trap_req && !trap_ack
    |=> trap_req && $stable(trap_cause) && !instr_ready)
    else $error("trap dropped before ack");
  a_guest_user: assert property (take && guest_mode && !debug_mode
    && !kernel_mode && instr_class == gtac_pkg::gtac_k_priv
    |=> trap_req && !trap_to_root && !instr_commit)
    else $error("guest user op not guest bound");
  a_timer_trap: assert property (take && guest_mode && !debug_mode
    && kernel_mode && instr_class == gtac_pkg::gtac_k_timer
    && ctl[gtac_pkg::CTL_TIMER] |=> trap_req && trap_cause == gtac_pkg::gtac_c_gpsi)
    else $error("guest timer access not trapped");
  a_sysreg_trap: assert property (take && guest_mode && !debug_mode
    && kernel_mode && instr_class == gtac_pkg::gtac_k_sysreg && !sysreg_exists
    |=> trap_req && trap_cause == gtac_pkg::gtac_c_gpsi)
    else $error("missing register access not trapped");
  a_debug_move: assert property (take && debug_mode
    && instr_class == gtac_pkg::gtac_k_rdg
    |=> guest_sysreg_rd && instr_commit && !trap_req)
    else $error("debug register read lost");
  a_root_write: assert property (take && !guest_mode && kernel_mode
    && instr_class == gtac_pkg::gtac_k_wrg
    |=> guest_sysreg_wr && instr_commit && !trap_req)
    else $error("root register write lost");
  a_one_outcome: assert property (trap_req |-> !instr_commit)
    else $error("trapped instruction took effect");
  a_exit_status: assert property ($rose(trap_req) && trap_to_root
    |-> (stat & gtac_pkg::cause_irq(trap_cause)) != '0)
    else $error("root exit left no status bit");

  c_field_trap: cover property (take ##1 trap_cause == gtac_pkg::gtac_c_gsfc && trap_req);
  c_hw_trap: cover property (hw_field_change ##[1:4] trap_cause == gtac_pkg::gtac_c_ghfc);
  c_irq_rise: cover property ($rose(irq));
  c_gsys_rd: cover property (guest_sysreg_rd && debug_mode);
  c_guest_exit: cover property (trap_req && !trap_to_root);
endmodule // gtac_top

/* tb_guest_trap_and_access_control.sv */
// Purpose: Self-checking bench for the guest trap and access control block
// Assumes: Bench acknowledges each trap in the cycle after it rises
// Notes: Driver queues expected results, a negedge monitor compares them
`timescale 1ns/1ns
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_guest_trap_and_access_control;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, instr_valid, guest_mode;
  logic kernel_mode, debug_mode, sysreg_exists, sysreg_disabled, field_change, rp_chg, iv_chg;
  logic hw_field_change, instr_ready, instr_commit, trap_req, trap_to_root, irq, tr_prev;
  logic guest_sysreg_rd, guest_sysreg_wr, guest_tlb_op;
  logic trap_ack = 1'b0;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic [10:0] ok, gp, ei;
  logic [32:0] ea;
  gtac_pkg::gtac_class_t instr_class;
  gtac_pkg::gtac_tlb_t tlb_code, guest_tlb_code;
  gtac_pkg::gtac_cause_t trap_cause, last_root;
  logic [10:0] iq[$];
  logic [32:0] aq[$];
  int fail_count = 0;
  int checks = 0;
  int exits = 0;

  gtac_top uut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .instr_valid, .instr_class, .tlb_code, .guest_mode, .kernel_mode, .debug_mode,
    .sysreg_exists, .sysreg_disabled, .field_change, .reduced_power_bit_chg(rp_chg),
    .interrupt_vector_sel_chg(iv_chg), .hw_field_change, .trap_ack, .instr_ready, .instr_commit,
    .trap_req, .trap_to_root, .trap_cause, .guest_sysreg_rd, .guest_sysreg_wr, .guest_tlb_op,
    .guest_tlb_code, .irq);

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Ack lands one cycle after trap_req rises, then drops
  always @(posedge pclk) trap_ack <= trap_req && !trap_ack;

  always @(negedge pclk) begin
    if (instr_commit || (trap_req && !tr_prev)) begin
      ei = (iq.size() == 0) ? 11'h7ff : iq.pop_front();
      `CHK({instr_commit, trap_to_root & trap_req, trap_req ? trap_cause : gtac_pkg::gtac_c_none,
        guest_sysreg_rd, guest_sysreg_wr, guest_tlb_op, guest_tlb_op ? guest_tlb_code : 3'h0},
        ei)
    end
    tr_prev = trap_req;
    if (psel && penable && pready) begin
      ea = aq.pop_front();
      `CHK({pslverr, pwrite ? 32'h0 : prdata}, ea)
    end
  end

  function automatic logic [10:0] tr(input logic r, input gtac_pkg::gtac_cause_t c);
    return {1'b0, r, c, 6'h00};
  endfunction

  function automatic logic [10:0] cm(input logic [2:0] s, input logic [2:0] k);
    return {1'b1, 1'b0, 3'h0, s, k};
  endfunction

  // Root-bound exits are tallied for the exit info check
  function automatic void note(input logic [10:0] e);
    if (e != 11'h7ff) begin
      iq.push_back(e);
      if (e[10:9] == 2'b01) begin
        exits++;
        last_root = gtac_pkg::gtac_cause_t'(e[8:6]);
      end
    end
  endfunction

  task automatic settle();
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while ((iq.size() != 0 || !instr_ready || trap_req) && n < 40);
    if (n >= 40) fail_count++;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    int n;
    n = 0;
    aq.push_back(e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (!pready && n < 20);
    if (!pready) fail_count++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic issue(input gtac_pkg::gtac_class_t c, input logic [2:0] m,
                       input logic [4:0] f, input logic [10:0] e);
    note(e);
    @(posedge pclk);
    instr_valid <= 1'b1;
    instr_class <= c;
    {guest_mode, kernel_mode, debug_mode} <= m;
    {sysreg_exists, sysreg_disabled, field_change, rp_chg, iv_chg} <= f;
    tlb_code <= gtac_pkg::gtac_tlb_t'(e[2:0]);
    @(posedge pclk);
    instr_valid <= 1'b0;
    settle();
  endtask

  task automatic hwc(input logic [10:0] e);
    note(e);
    @(posedge pclk);
    hw_field_change <= 1'b1;
    @(posedge pclk);
    hw_field_change <= 1'b0;
    settle();
  endtask

  task automatic stop_test();
    if (fail_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    #200000;
    fail_count++;
    stop_test();
  end

  initial begin
    v = $urandom(9892);
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, instr_valid, tr_prev} = '0;
    {guest_mode, kernel_mode, debug_mode, sysreg_exists, sysreg_disabled} = '0;
    {field_change, rp_chg, iv_chg, hw_field_change} = '0;
    instr_class = gtac_pkg::gtac_k_plain;
    tlb_code = gtac_pkg::gtac_t_inv;
    ok = cm(3'h0, 3'h0);
    gp = tr(1'b1, gtac_pkg::gtac_c_gpsi);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    for (int i = 0; i < 20; i += 4) apb(1'b0, 8'(i), 32'h0, 33'h0);
    apb(1'b0, 8'h20, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 8'h24, v, {1'b1, 32'h0});
    v = $urandom & 32'h3f;
    apb(1'b1, gtac_pkg::OFS_CTL, v, 33'h0);
    apb(1'b0, gtac_pkg::OFS_CTL, 32'h0, {1'b0, v});
    apb(1'b1, gtac_pkg::OFS_INT_MASK, 32'h1f, 33'h0);
    apb(1'b1, gtac_pkg::OFS_CTL, 32'h0, 33'h0);
    issue(gtac_pkg::gtac_k_priv, 3'b110, 5'h10, ok);
    issue(gtac_pkg::gtac_k_priv, 3'b100, 5'h10, tr(1'b0, gtac_pkg::gtac_c_guest));
    issue(gtac_pkg::gtac_k_plain, 3'b110, 5'h14, tr(1'b1, gtac_pkg::gtac_c_gsfc));
    issue(gtac_pkg::gtac_k_plain, 3'b110, 5'h12, tr(1'b1, gtac_pkg::gtac_c_gsfc));
    issue(gtac_pkg::gtac_k_plain, 3'b110, 5'h11, tr(1'b1, gtac_pkg::gtac_c_gsfc));
    hwc(tr(1'b1, gtac_pkg::gtac_c_ghfc));
    for (int b = 1; b < 5; b++) begin
      apb(1'b1, gtac_pkg::OFS_CTL, 32'h1 << b, 33'h0);
      issue(gtac_pkg::gtac_class_t'(b + 1), 3'b110, 5'h10, gp);
      issue(gtac_pkg::gtac_class_t'(b % 4 + 2), 3'b110, 5'h10, ok);
    end
    apb(1'b1, gtac_pkg::OFS_CTL, 32'h1, 33'h0);
    issue(gtac_pkg::gtac_k_priv, 3'b110, 5'h14, gp);
    apb(1'b1, gtac_pkg::OFS_CTL, 32'h0, 33'h0);
    issue(gtac_pkg::gtac_k_sysreg, 3'b110, 5'h00, gp);
    issue(gtac_pkg::gtac_k_sysreg, 3'b110, 5'h18, gp);
    issue(gtac_pkg::gtac_k_sysreg, 3'b110, 5'h10, ok);
    issue(gtac_pkg::gtac_k_resv, 3'b110, 5'h10, tr(1'b0, gtac_pkg::gtac_c_guest));
    apb(1'b1, gtac_pkg::OFS_CTL, 32'h20, 33'h0);
    issue(gtac_pkg::gtac_k_resv, 3'b110, 5'h10, tr(1'b1, gtac_pkg::gtac_c_gri));
    issue(gtac_pkg::gtac_k_hcall, 3'b110, 5'h10, tr(1'b1, gtac_pkg::gtac_c_hcall));
    issue(gtac_pkg::gtac_k_hcall, 3'b010, 5'h10, tr(1'b1, gtac_pkg::gtac_c_hcall));
    issue(gtac_pkg::gtac_k_rdg, 3'b010, 5'h10, cm(3'b100, 3'h0));
    issue(gtac_pkg::gtac_k_wrg, 3'b010, 5'h10, cm(3'b010, 3'h0));
    issue(gtac_pkg::gtac_k_rdg, 3'b111, 5'h10, cm(3'b100, 3'h0));
    issue(gtac_pkg::gtac_k_tlb, 3'b111, 5'h10, cm(3'b001, 3'h3));
    issue(gtac_pkg::gtac_k_rdg, 3'b110, 5'h10, gp);
    issue(gtac_pkg::gtac_k_rdg, 3'b000, 5'h10, 11'h7ff);
    for (int t = 0; t < 6; t++) issue(gtac_pkg::gtac_k_tlb, 3'b010, 5'h10, cm(3'b001, 3'(t)));
    apb(1'b1, gtac_pkg::OFS_CTL_EXT, 32'h1, 33'h0);
    issue(gtac_pkg::gtac_k_plain, 3'b110, 5'h17, ok);
    hwc(11'h7ff);
    apb(1'b1, gtac_pkg::OFS_CTL_EXT, 32'h0, 33'h0);
    apb(1'b0, gtac_pkg::OFS_EXIT_INFO, 32'h0, {17'h0, 8'(exits), 4'h0, 1'b1, last_root});
    apb(1'b0, gtac_pkg::OFS_INT_STAT, 32'h0, 33'h1f);
    `CHK(irq, 1'b1)
    apb(1'b1, gtac_pkg::OFS_INT_MASK, 32'h0, 33'h0);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    apb(1'b1, gtac_pkg::OFS_INT_MASK, 32'h1f, 33'h0);
    apb(1'b1, gtac_pkg::OFS_INT_STAT, 32'h1f, 33'h0);
    apb(1'b0, gtac_pkg::OFS_INT_STAT, 32'h0, 33'h0);
    `CHK(irq, 1'b0)
    stop_test();
  end
endmodule // tb_guest_trap_and_access_control
